// ### tb_wpad_top.sv
// Self-checking bench for the receive decoder, FSK reply and loss monitor.
// Assumes wpad_pkg and wpad_rx_model are compiled first.
`timescale 1ns/1ps
`include "wpad_regs.svh"
module tb_wpad_top;
  import wpad_pkg::*;
  localparam int B = 40;
  localparam int F = 40;
  logic        clk, rst_n, act, rdy, fst, env, glt;
  logic [11:0] strap;
  logic [7:0]  txp, fbyte, rx, pd;
  logic        pv, pl, pg, busy, shift, ach, fod, shut, s0;
  logic [2:0]  scale;
  logic [7:0]  q[$];
  int          miscompares, checks, n, t;

  wpad_top #(.BIT_CYCLES(B), .FSK_BIT_CYCLES(F)) wpad_top_inst (
    .I_CLOCK(clk), .I_RST_N(rst_n), .I_COIL_VOLTAGE_DEMOD_IN(env ^ glt),
    .I_INPUT_CURRENT_DEMOD_IN(env), .I_THRESHOLD_STRAP_PIN(strap),
    .I_POWER_TRANSFER_ACTIVE(act), .I_TX_POWER(txp), .O_PKT_VALID(pv),
    .O_PKT_DATA(pd), .O_PKT_LAST(pl), .O_PKT_GOOD(pg), .I_PKT_READY(rdy),
    .I_FSK_START(fst), .I_FSK_BYTE(fbyte), .O_FSK_BUSY(busy), .O_FSK_SHIFT(shift),
    .O_ACTIVE_CHANNEL(ach), .O_THRESH_SCALE(scale), .O_FOD_FAULT(fod),
    .O_SHUTDOWN(shut));
  wpad_rx_model #(.BIT_CYCLES(B)) wpad_rx_model_inst (.i_clk(clk), .o_env(env));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      miscompares++;
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic [2:0] exp_scale(input logic [11:0] v);
    if (v < `WPAD_BAND1_MV) return 3'h1;
    if (v < `WPAD_BAND2_MV) return 3'h2;
    if (v < `WPAD_BAND3_MV) return 3'h3;
    return 3'h4;
  endfunction
  task automatic do_reset(input logic [11:0] v);
    rst_n = 1'b0;
    strap = v;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (12) @(negedge clk);
  endtask
  // Bytes wait in the buffer while ready is low, then drain back to back.
  task automatic drain(input logic good);
    rdy = 1'b1;
    foreach (q[i]) begin
      n = 0;
      while (pv !== 1'b1 && n < 100) begin
        @(negedge clk);
        n++;
      end
      if (n >= 100) begin
        miscompares++;
        give_verdict();
      end
      compare(pd, q[i]);
      compare(pl, i == q.size() - 1);
      if (i == q.size() - 1) compare(pg, good);
      @(negedge clk);
    end
    compare(pv, 1'b0);
    rdy = 1'b0;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0; act = 1'b0; rdy = 1'b0; fst = 1'b0; glt = 1'b0;
    strap = 12'h000; txp = 8'h00; fbyte = 8'h00;
    miscompares = 0; checks = 0;
    void'($urandom(3614));
    for (int k = 0; k < 4; k++) begin
      do_reset(12'(k * 700 + $urandom % (k == 3 ? 300 : 700)));
      compare(scale, exp_scale(strap));
      compare({pv, busy, fod, shut}, 4'h0);
    end
    fbyte = 8'($urandom);
    s0 = shift;
    fst = 1'b1;
    @(negedge clk);
    fst = 1'b0;
    compare(busy, 1'b1);
    n = 0; t = 0;
    while (busy === 1'b1 && n < 2000) begin
      if (shift !== s0) t++;
      s0 = shift;
      n++;
      @(negedge clk);
    end
    if (n >= 2000) begin
      miscompares++;
      give_verdict();
    end
    compare(n, 11 * F);
    compare(t, 12 + $countones(fbyte) + (~^fbyte));
    act = 1'b1;
    rx = 8'($urandom % 64);
    txp = rx;
    q = {8'h10, rx, 8'h10 ^ rx};
    wpad_rx_model_inst.send_packet(q);
    drain(1'b1);
    // Short pulses on the voltage envelope alone drop its quality below the current one.
    for (int g = 0; g < 4; g++) begin
      glt = 1'b1;
      repeat (3) @(negedge clk);
      glt = 1'b0;
      repeat (20) @(negedge clk);
    end
    repeat (60) @(negedge clk);
    compare(ach, 1'b1);
    q = {8'h10, 8'($urandom), 8'h00};
    q[2] = q[0] ^ q[1] ^ 8'h01;
    wpad_rx_model_inst.send_packet(q);
    drain(1'b0);
    compare(ach, 1'b0);
    txp = rx + `WPAD_DEFAULT_FOD * exp_scale(strap);
    repeat (5) @(negedge clk);
    compare(fod, 1'b0);
    txp = txp + 8'h01;
    repeat (2) @(negedge clk);
    compare({fod, shut}, 2'h3);
    fst = 1'b1;
    @(negedge clk);
    fst = 1'b0;
    @(negedge clk);
    compare(busy, 1'b0);
    give_verdict();
  end
endmodule

// ### wpad_fifo.sv
// Small first-word-fall-through buffer whose head entry is a register.
// Assumes a synchronous environment on one clock with an already synchronised reset.
`timescale 1ns/1ps
module wpad_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
)(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // Filling side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Draining side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] ent;
    logic [CW-1:0]               cnt;
    logic                        full;
    logic                        vld;
  } wpad_fifo_state_type;

  wpad_fifo_state_type s;
  wpad_fifo_state_type n;

  // ****************************************
  // Shift-down storage
  // ****************************************
  // Shifting costs a little area but keeps the head in a fixed register.
  always_comb begin
    logic          push;
    logic          pop;
    logic [CW-1:0] idx;
    push = i_in_valid && !s.full;
    pop  = i_out_ready && s.vld;
    idx  = '0;
    n    = s;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        n.ent[i] = s.ent[i+1];
      end
    end
    idx = pop ? s.cnt - CW'(1) : s.cnt;
    if (push) begin
      n.ent[idx] = i_in_data;
    end
    n.cnt  = s.cnt + CW'(push) - CW'(pop);
    n.full = (n.cnt == CW'(DEPTH));
    n.vld  = (n.cnt != '0);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign o_in_ready  = !s.full;
  assign o_out_valid = s.vld;
  assign o_out_data  = s.ent[0];

  fifo_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s.full && !i_out_ready) |=> (s.full && $stable(s.ent[0])))
    else $error("Full buffer changed without a pop.");
endmodule

// ### wpad_pkg.sv
// Types of the receive decoder, also imported by its bench; the packet buffer keeps its own.
// Assumes wpad_regs.svh is on the include path.
package wpad_pkg;
`include "wpad_regs.svh"

  // ****************************************
  // Packet assembler states
  // ****************************************
  typedef enum logic [1:0] {
    PK_IDLE = 2'b00,
    PK_BYTE = 2'b01,
    PK_GAP  = 2'b10
  } wpad_pkt_state_type;

  // ****************************************
  // Whole state of the top module apart from the reset release stages
  // ****************************************
  typedef struct packed {
    logic [1:0]                       dem1;
    logic [1:0]                       dem2;
    logic [`WPAD_STRAP_W-1:0]         strap1;
    logic [`WPAD_STRAP_W-1:0]         strap2;
    logic [1:0]                       strap_wait;
    logic [1:0]                       ch_lvl;
    logic [1:0][`WPAD_CNT_W-1:0]      ch_cnt;
    logic [1:0]                       ch_half;
    logic [1:0][3:0]                  ch_qual;
    logic                             sel;
    wpad_pkt_state_type               pk_state;
    logic [3:0]                       pre_cnt;
    logic [3:0]                       bit_cnt;
    logic [3:0]                       byte_cnt;
    logic [`WPAD_CNT_W-1:0]           idle_cnt;
    logic [9:0]                       shreg;
    logic [7:0]                       hold;
    logic [7:0]                       xsum;
    logic [7:0]                       hdr;
    logic [7:0]                       msg0;
    logic                             pkt_bad;
    logic                             push_v;
    logic [9:0]                       push_d;
    logic [2:0]                       scale;
    logic                             scale_done;
    logic [7:0]                       rx_pwr;
    logic                             rx_ok;
    logic                             fod_fault;
    logic                             shutdown;
    logic                             fsk_busy;
    logic [10:0]                      fsk_bits;
    logic [3:0]                       fsk_bitn;
    logic [`WPAD_CNT_W-1:0]           fsk_cnt;
    logic                             fsk_second;
    logic                             fsk_out;
  } wpad_state_type;
endpackage

// ### wpad_regs.svh
// Constants of the wireless power receive decoder, FSK reply and loss monitor.
// Assumes a 250 MHz system clock and a strap pin sampled by an external ADC in millivolts.
`ifndef WPAD_REGS_SVH
`define WPAD_REGS_SVH

// ****************************************
// Timing
// ****************************************
`define WPAD_CLK_PERIOD_NS    4
`define WPAD_ASK_BIT_RATE_HZ  2000
`define WPAD_FSK_BIT_NS       500000
`define WPAD_CNT_W            18

// ****************************************
// Framing and selection
// ****************************************
`define WPAD_DATA_BITS        8
`define WPAD_FRAME_BITS       11
`define WPAD_LAST_BIT_IDX     4'h9
`define WPAD_PREAMBLE_MIN     4'h4
`define WPAD_QUAL_MAX         4'hF
`define WPAD_QUAL_PENALTY     4'h4
`define WPAD_RPP_HEADER       8'h10
`define WPAD_FIFO_DEPTH       4

// ****************************************
// Loss thresholds
// ****************************************
`define WPAD_STRAP_W          12
`define WPAD_BAND1_MV         12'h2BC
`define WPAD_BAND2_MV         12'h578
`define WPAD_BAND3_MV         12'h834
`define WPAD_DEFAULT_FOD      8'h20

`endif

// ### wpad_rx_model.sv
// Behavioural wireless power receiver that load-modulates one envelope line.
// Assumes the bench clock paces it; bit times are counted in its falling edges.
`timescale 1ns/1ps
module wpad_rx_model #(
  parameter int BIT_CYCLES = 40
)(
  input  wire logic i_clk,
  output logic      o_env
);
  initial o_env = 1'b0;
  // Level changes at each bit start and again mid-bit for a one.
  task automatic send_bit(input logic b);
    o_env = ~o_env;
    repeat (BIT_CYCLES / 2) @(negedge i_clk);
    if (b) o_env = ~o_env;
    repeat (BIT_CYCLES / 2) @(negedge i_clk);
  endtask
  // Eleven bit periods: start, data LSB first, odd parity, stop.
  task automatic send_byte(input logic [7:0] d);
    send_bit(1'b0);
    for (int i = 0; i < 8; i++) send_bit(d[i]);
    send_bit(~^d);
    send_bit(1'b1);
  endtask
  // The trailing edge closes the last stop bit; the idle time then ends the packet.
  task automatic send_packet(input logic [7:0] q[$]);
    repeat (8) send_bit(1'b1);
    foreach (q[i]) send_byte(q[i]);
    o_env = ~o_env;
    repeat (3 * BIT_CYCLES) @(negedge i_clk);
  endtask
endmodule

// ### wpad_top.sv
// Receive decoder for load-modulated packets, FSK reply modulator and power loss monitor.
// Assumes the envelope comparators and the strap ADC are asynchronous to I_CLOCK.
`timescale 1ns/1ps
`include "wpad_regs.svh"
module wpad_top import wpad_pkg::*; #(
  parameter int         BIT_CYCLES     =
    1000000000 / (`WPAD_ASK_BIT_RATE_HZ * `WPAD_CLK_PERIOD_NS),
  parameter int         FSK_BIT_CYCLES = `WPAD_FSK_BIT_NS / `WPAD_CLK_PERIOD_NS,
  parameter logic [7:0] DEFAULT_FOD    = `WPAD_DEFAULT_FOD,
  parameter logic [7:0] RPP_HEADER     = `WPAD_RPP_HEADER,
  parameter int         FIFO_DEPTH     = `WPAD_FIFO_DEPTH
)(
  // Clock and reset
  input  wire logic                     I_CLOCK,
  input  wire logic                     I_RST_N,
  // Envelope comparator pins
  input  wire logic                     I_COIL_VOLTAGE_DEMOD_IN,
  input  wire logic                     I_INPUT_CURRENT_DEMOD_IN,
  // Strap ADC code in millivolts
  input  wire logic [`WPAD_STRAP_W-1:0] I_THRESHOLD_STRAP_PIN,
  // Power stage status
  input  wire logic                     I_POWER_TRANSFER_ACTIVE,
  input  wire logic [7:0]               I_TX_POWER,
  // Packet byte stream
  output logic                          O_PKT_VALID,
  output logic [7:0]                    O_PKT_DATA,
  output logic                          O_PKT_LAST,
  output logic                          O_PKT_GOOD,
  input  wire logic                     I_PKT_READY,
  // FSK reply
  input  wire logic                     I_FSK_START,
  input  wire logic [7:0]               I_FSK_BYTE,
  output logic                          O_FSK_BUSY,
  output logic                          O_FSK_SHIFT,
  // Status
  output logic                          O_ACTIVE_CHANNEL,
  output logic [2:0]                    O_THRESH_SCALE,
  output logic                          O_FOD_FAULT,
  output logic                          O_SHUTDOWN
);
  localparam int                    CW      = `WPAD_CNT_W;
  localparam logic [CW-1:0]         Q1      = CW'(BIT_CYCLES / 4);
  localparam logic [CW-1:0]         Q3      = CW'((3 * BIT_CYCLES) / 4);
  localparam logic [CW-1:0]         Q5      = CW'((5 * BIT_CYCLES) / 4);
  localparam logic [CW-1:0]         IDLE    = CW'(2 * BIT_CYCLES);
  localparam logic [CW-1:0]         FHALF   = CW'(FSK_BIT_CYCLES / 2 - 1);
  localparam logic [CW-1:0]         CNT_MAX = '1;

  wpad_state_type s;
  wpad_state_type n;
  logic [1:0]     rst_q;
  logic           rst_n;
  logic           fifo_ready;
  logic [9:0]     fifo_q;
  logic [7:0]     loss;
  logic [10:0]    thresh;
  logic [1:0]     bv_w;

  // ****************************************
  // Reset release
  // ****************************************
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Loss against the scaled threshold.
  assign loss   = (I_TX_POWER > s.rx_pwr) ? I_TX_POWER - s.rx_pwr : 8'h00;
  assign thresh = 11'(DEFAULT_FOD) * 11'(s.scale);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [1:0] bv;
    logic [1:0] bd;
    logic [1:0] err;
    logic       sbv;
    logic       sbd;
    logic       tout;
    logic       byte_done;
    logic       finish;
    logic       frame_ok;
    logic       good;
    logic [7:0] dbyte;
    bv        = 2'b00;
    bd        = 2'b00;
    err       = 2'b00;
    sbv       = 1'b0;
    sbd       = 1'b0;
    tout      = 1'b0;
    byte_done = 1'b0;
    finish    = 1'b0;
    frame_ok  = 1'b0;
    good      = 1'b0;
    dbyte     = 8'h00;
    n         = s;
    n.push_v  = 1'b0;
    // Both envelopes are synchronised; the first stage feeds only the second.
    n.dem1   = {I_INPUT_CURRENT_DEMOD_IN, I_COIL_VOLTAGE_DEMOD_IN};
    n.dem2   = s.dem1;
    n.strap1 = I_THRESHOLD_STRAP_PIN;
    n.strap2 = s.strap1;

    // Bi-phase timing per envelope; a long quiet gap only resynchronises.
    for (int c = 0; c < 2; c++) begin
      n.ch_lvl[c] = s.dem2[c];
      if (s.dem2[c] == s.ch_lvl[c]) begin
        if (s.ch_cnt[c] != CNT_MAX) begin
          n.ch_cnt[c] = s.ch_cnt[c] + CW'(1);
        end
      end else begin
        n.ch_cnt[c] = '0;
        if (s.ch_cnt[c] < Q1) begin
          err[c]       = 1'b1;
          n.ch_half[c] = 1'b0;
        end else if (s.ch_cnt[c] < Q3) begin
          if (s.ch_half[c]) begin
            bv[c]        = 1'b1;
            bd[c]        = 1'b1;
            n.ch_half[c] = 1'b0;
          end else begin
            n.ch_half[c] = 1'b1;
          end
        end else if (s.ch_cnt[c] < Q5) begin
          if (s.ch_half[c]) begin
            err[c]       = 1'b1;
            n.ch_half[c] = 1'b0;
          end else begin
            bv[c] = 1'b1;
          end
        end else begin
          n.ch_half[c] = 1'b0;
        end
      end
      if (bv[c] && s.ch_qual[c] != `WPAD_QUAL_MAX) begin
        n.ch_qual[c] = s.ch_qual[c] + 4'h1;
      end else if (err[c]) begin
        n.ch_qual[c] = (s.ch_qual[c] > `WPAD_QUAL_PENALTY) ?
                       s.ch_qual[c] - `WPAD_QUAL_PENALTY : 4'h0;
      end
    end

    // The source is only switched between packets so a packet never mixes envelopes.
    if (s.pk_state == PK_IDLE && s.pre_cnt == 4'h0) begin
      n.sel = (s.ch_qual[1] > s.ch_qual[0]);
    end
    sbv = bv[s.sel];
    sbd = bd[s.sel];
    if (sbv) begin
      n.idle_cnt = '0;
    end else if (s.idle_cnt != CNT_MAX) begin
      n.idle_cnt = s.idle_cnt + CW'(1);
    end
    tout     = !sbv && (s.idle_cnt >= IDLE);
    dbyte    = s.shreg[8:1];
    frame_ok = sbd && (^s.shreg[9:1]);

    // Preamble, then framed bytes, closed by silence or a stray one.
    unique case (s.pk_state)
      PK_IDLE: begin
        if (tout) begin
          n.pre_cnt = 4'h0;
        end else if (sbv && sbd) begin
          if (s.pre_cnt != 4'hF) begin
            n.pre_cnt = s.pre_cnt + 4'h1;
          end
        end else if (sbv) begin
          if (s.pre_cnt >= `WPAD_PREAMBLE_MIN) begin
            n.pk_state = PK_BYTE;
            n.bit_cnt  = 4'h0;
          end
          n.pre_cnt = 4'h0;
        end
      end
      PK_BYTE: begin
        if (tout) begin
          finish = 1'b1;
        end else if (sbv) begin
          n.shreg   = {sbd, s.shreg[9:1]};
          n.bit_cnt = s.bit_cnt + 4'h1;
          if (s.bit_cnt == `WPAD_LAST_BIT_IDX) begin
            byte_done  = 1'b1;
            n.pk_state = PK_GAP;
          end
        end
      end
      PK_GAP: begin
        if (tout || (sbv && sbd)) begin
          finish = 1'b1;
        end else if (sbv) begin
          n.pk_state = PK_BYTE;
          n.bit_cnt  = 4'h0;
        end
      end
      default: begin
        n.pk_state = PK_IDLE;
      end
    endcase

    // Each byte is held back one slot so the last one can carry the verdict.
    if (byte_done) begin
      if (!frame_ok) begin
        n.pkt_bad = 1'b1;
      end
      n.xsum = s.xsum ^ dbyte;
      if (s.byte_cnt == 4'h0) begin
        n.hdr = dbyte;
      end
      if (s.byte_cnt == 4'h1) begin
        n.msg0 = dbyte;
      end
      if (s.byte_cnt != 4'hF) begin
        n.byte_cnt = s.byte_cnt + 4'h1;
      end
      if (s.byte_cnt != 4'h0) begin
        if (fifo_ready) begin
          n.push_v = 1'b1;
          n.push_d = {2'b00, s.hold};
        end else begin
          n.pkt_bad = 1'b1;
        end
      end
      n.hold = dbyte;
    end
    if (finish) begin
      good = (s.pk_state == PK_GAP) && !s.pkt_bad && (s.xsum == 8'h00) &&
             (s.byte_cnt >= 4'h2);
      if (s.byte_cnt != 4'h0 && fifo_ready) begin
        n.push_v = 1'b1;
        n.push_d = {good, 1'b1, s.hold};
      end
      if (good && s.hdr == RPP_HEADER && s.byte_cnt >= 4'h3) begin
        n.rx_pwr = s.msg0;
        n.rx_ok  = 1'b1;
      end
      n.pk_state = PK_IDLE;
      n.pre_cnt  = 4'h0;
      n.byte_cnt = 4'h0;
      n.xsum     = 8'h00;
      n.pkt_bad  = 1'b0;
    end

    // Strap band is caught once, after the synchroniser has filled.
    if (!s.scale_done) begin
      if (s.strap_wait == 2'h3) begin
        n.scale_done = 1'b1;
        if (s.strap2 < `WPAD_BAND1_MV) begin
          n.scale = 3'h1;
        end else if (s.strap2 < `WPAD_BAND2_MV) begin
          n.scale = 3'h2;
        end else if (s.strap2 < `WPAD_BAND3_MV) begin
          n.scale = 3'h3;
        end else begin
          n.scale = 3'h4;
        end
      end else begin
        n.strap_wait = s.strap_wait + 2'h1;
      end
    end

    // Fault and shutdown latch until reset.
    if (!I_POWER_TRANSFER_ACTIVE) begin
      n.rx_ok = 1'b0;
    end else if (s.rx_ok && s.scale_done && {3'h0, loss} > thresh) begin
      n.fod_fault = 1'b1;
      n.shutdown  = 1'b1;
    end

    // Reply frame: bi-phase on the power frequency shift.
    if (!s.fsk_busy) begin
      if (I_FSK_START && !s.shutdown) begin
        n.fsk_busy   = 1'b1;
        n.fsk_bits   = {1'b1, ~^I_FSK_BYTE, I_FSK_BYTE, 1'b0};
        n.fsk_bitn   = 4'h0;
        n.fsk_cnt    = '0;
        n.fsk_second = 1'b0;
        n.fsk_out    = ~s.fsk_out;
      end
    end else if (s.fsk_cnt == FHALF) begin
      n.fsk_cnt = '0;
      if (!s.fsk_second) begin
        n.fsk_second = 1'b1;
        if (s.fsk_bits[0]) begin
          n.fsk_out = ~s.fsk_out;
        end
      end else begin
        n.fsk_second = 1'b0;
        n.fsk_bits   = {1'b0, s.fsk_bits[10:1]};
        if (s.fsk_bitn == 4'(`WPAD_FRAME_BITS - 1)) begin
          n.fsk_busy = 1'b0;
        end else begin
          n.fsk_bitn = s.fsk_bitn + 4'h1;
          n.fsk_out  = ~s.fsk_out;
        end
      end
    end else begin
      n.fsk_cnt = s.fsk_cnt + CW'(1);
    end
    bv_w = bv;
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ****************************************
  // Packet buffer and outputs
  // ****************************************
  wpad_fifo #(
    .WIDTH (10),
    .DEPTH (FIFO_DEPTH)
  ) wpad_fifo_inst (
    .i_clk       (I_CLOCK),
    .i_rst_n     (rst_n),
    .i_in_valid  (s.push_v),
    .i_in_data   (s.push_d),
    .o_in_ready  (fifo_ready),
    .o_out_valid (O_PKT_VALID),
    .o_out_data  (fifo_q),
    .i_out_ready (I_PKT_READY)
  );

  assign O_PKT_DATA       = fifo_q[7:0];
  assign O_PKT_LAST       = fifo_q[8];
  assign O_PKT_GOOD       = fifo_q[9];
  assign O_FSK_BUSY       = s.fsk_busy;
  assign O_FSK_SHIFT      = s.fsk_out;
  assign O_ACTIVE_CHANNEL = s.sel;
  assign O_THRESH_SCALE   = s.scale;
  assign O_FOD_FAULT      = s.fod_fault;
  assign O_SHUTDOWN       = s.shutdown;

  // ****************************************
  // Checks
  // ****************************************
  fault_shutdown_a: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
    $rose(s.fod_fault) |-> (s.shutdown ##1 s.shutdown [*3]))
    else $error("Fault without lasting shutdown.");
  fault_active_a: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
    $rose(s.fod_fault) |-> $past(I_POWER_TRANSFER_ACTIVE))
    else $error("Fault raised outside power transfer.");
  loss_trip_a: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
    (I_POWER_TRANSFER_ACTIVE && s.rx_ok && s.scale_done && {3'h0, loss} > thresh)
    |=> s.fod_fault)
    else $error("Loss above threshold did not trip.");
  strap_band_a: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
    $rose(s.scale_done) |-> ((s.scale == 3'h1) == ($past(s.strap2) < `WPAD_BAND1_MV)))
    else $error("Strap band scale wrong.");
  chk_good_a: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
    (s.push_v && s.push_d[9]) |-> ($past(s.xsum) == 8'h00 && !$past(s.pkt_bad)))
    else $error("Good packet with bad checksum.");
  frame_len_a: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
    (s.pk_state == PK_BYTE) |-> (s.bit_cnt <= `WPAD_LAST_BIT_IDX))
    else $error("Byte frame overran eleven bits.");
  bit_pair_a: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
    bv_w[0] |=> !s.ch_half[0])
    else $error("Half transition left pending after a bit.");
  sel_hold_a: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
    (s.pk_state != PK_IDLE) |=> (s.sel == $past(s.sel)))
    else $error("Envelope switched inside a packet.");
  fsk_start_a: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
    (I_FSK_START && !s.fsk_busy && !s.shutdown) |=> (s.fsk_busy && $changed(s.fsk_out)))
    else $error("Reply did not start.");
endmodule
